// >>> low_voltage_reset_monitor.sv
// low-voltage reset monitor: filters, reset generation, status and apb registers
// Functional notes
// - monitor is enabled straight out of reset, no software needed.
// - monitor power bit clear ignores comparator; no flag change, no reset.
// - reset only after supply low for nine or more consecutive cpu cycles.
// - held reset releases after one cpu cycle above the rising level.
// - external reset pin pulled low while low-voltage reset is active.
// - flag follows comparator and reads without side effects.
// - power set, reset enable clear: flag updates, never any reset.
// - reset needs both power and reset enable set.
// - flag sets after 32 to 40 crystal cycles low, clears above rising.
// - system reset clears the status flag.
// - monitor raises no processor interrupt; outputs are flag and reset (code adds event_irq from masked event flags).
// - in wait mode monitor keeps filtering and updating while powered.
// - in wait mode a qualified trip resets and leaves wait mode.
// - in stop with stop monitor set, trip bypasses filter to reset.
// - in stop with stop monitor clear, monitor is inactive.
`timescale 1ns/1ps
`include "lvm_consts.svh"

module low_voltage_reset_monitor
   import lvm_pkg::*;
#(
   parameter int CPU_FILTER = `LVM_CPU_FILTER,
   parameter int FLAG_SET   = `LVM_FLAG_SET
) (
   input  wire logic        sys_clk,
   input  wire logic        reset,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   output logic             pready,
   output logic [31:0]      prdata,
   output logic             pslverr,
   input  wire logic        below_falling_raw,
   input  wire logic        above_rising_raw,
   input  wire logic        cpu_cycle_en,
   input  wire logic        crystal_clock_en,
   input  wire logic        wait_mode,
   input  wire logic        stop_mode,
   output logic             low_voltage_reset,
   output logic             reset_pin_out,
   output logic             reset_pin_oe,
   output logic             event_irq
);

   // ----------------------------------------------------------------
   // elaboration checks
   // ----------------------------------------------------------------
   if (CPU_FILTER < 1 || CPU_FILTER > 15) begin : g_bad_filter
      $error("CPU_FILTER must be 1 to 15");
   end
   if (FLAG_SET < `LVM_FLAG_MIN || FLAG_SET > `LVM_FLAG_MAX) begin : g_bad_flag
      $error("FLAG_SET must lie in the documented window");
   end

   localparam logic [3:0] CPU_MAX  = 4'(CPU_FILTER);
   localparam logic [5:0] FLAG_MAX = 6'(FLAG_SET);

   apb_req_s   req;
   cfg_s       cfg;
   mon_state_e state;
   logic [2:0] below_sync;
   logic [2:0] above_sync;
   logic       below;
   logic       above;
   logic       active;
   logic       bypass;
   logic [3:0] cpu_cnt;
   logic [5:0] xtal_cnt;
   logic       low_voltage_flag;
   logic [1:0] evt_status;
   logic [1:0] evt_mask;
   logic [1:0] evt_set;
   logic       wr_en;
   logic       rd_en;
   logic       mapped;
   logic       next_flag;
   logic       trip;

   assign req = '{psel, penable, pwrite, paddr, pwdata};

   // ----------------------------------------------------------------
   // comparator synchronisers
   // ----------------------------------------------------------------
   always_ff @(posedge sys_clk) begin
      if (reset) begin
         below_sync <= 3'h0;
         above_sync <= 3'h0;
      end else begin
         below_sync <= {below_sync[1:0], below_falling_raw};
         above_sync <= {above_sync[1:0], above_rising_raw};
      end
   end

   // settled levels: a change counts once stages two and three agree
   always_ff @(posedge sys_clk) begin
      if (reset) begin
         below <= 1'b0;
         above <= 1'b0;
      end else begin
         if (below_sync[1] == below_sync[2]) begin
            below <= below_sync[2];
         end
         if (above_sync[1] == above_sync[2]) begin
            above <= above_sync[2];
         end
      end
   end

   // ----------------------------------------------------------------
   // activity qualification
   // ----------------------------------------------------------------
   // wait mode does not gate the monitor
   assign active = cfg.monitor_power_enable &&
                   (!stop_mode || cfg.stop_mode_monitor_enable);
   assign bypass = stop_mode && cfg.stop_mode_monitor_enable;

   // ----------------------------------------------------------------
   // cpu-cycle filter
   // ----------------------------------------------------------------
   always_ff @(posedge sys_clk) begin
      if (reset) begin
         cpu_cnt <= 4'h0;
      end else if (!active || !below) begin
         cpu_cnt <= 4'h0;
      end else if (cpu_cycle_en && cpu_cnt != CPU_MAX) begin
         cpu_cnt <= cpu_cnt + 4'h1;
      end
   end

   assign trip = cfg.monitor_power_enable && cfg.low_voltage_reset_enable && active &&
                 ((cpu_cnt == CPU_MAX) || (bypass && below));

   // ----------------------------------------------------------------
   // reset generator
   // ----------------------------------------------------------------
   always_ff @(posedge sys_clk) begin
      if (reset) begin
         state <= MON_RUN;
      end else begin
         case (state)
            MON_RUN: begin
               if (trip) begin
                  state <= MON_RESET;
               end
            end
            MON_RESET: begin
               if (!cfg.monitor_power_enable || !cfg.low_voltage_reset_enable) begin
                  state <= MON_RUN;
               end else if (above && (cpu_cycle_en || stop_mode)) begin
                  state <= MON_RUN;
               end
            end
            default: begin
               state <= MON_RUN;
            end
         endcase
      end
   end

   // chip reset and open-drain pin drive low together
   always_ff @(posedge sys_clk) begin
      if (reset) begin
         low_voltage_reset <= 1'b0;
         reset_pin_out     <= 1'b0;
         reset_pin_oe      <= 1'b0;
      end else begin
         low_voltage_reset <= (state == MON_RESET);
         reset_pin_out     <= 1'b0;
         reset_pin_oe      <= (state == MON_RESET);
      end
   end

   // ----------------------------------------------------------------
   // crystal-clock flag filter
   // ----------------------------------------------------------------
   always_ff @(posedge sys_clk) begin
      if (reset) begin
         xtal_cnt <= 6'h00;
      end else if (!active || !below) begin
         xtal_cnt <= 6'h00;
      end else if (crystal_clock_en && xtal_cnt != FLAG_MAX) begin
         xtal_cnt <= xtal_cnt + 6'h01;
      end
   end

   always_comb begin
      next_flag = low_voltage_flag;
      if (active) begin
         if (above) begin
            next_flag = 1'b0;
         end else if (below && xtal_cnt == FLAG_MAX) begin
            // set only while still low, so the band keeps the old value
            next_flag = 1'b1;
         end
      end
   end

   always_ff @(posedge sys_clk) begin
      if (reset) begin
         low_voltage_flag <= 1'b0;
      end else begin
         low_voltage_flag <= next_flag;
      end
   end

   // ----------------------------------------------------------------
   // apb slave
   // ----------------------------------------------------------------
   assign wr_en  = req.psel && req.penable && pready && req.pwrite;
   assign rd_en  = req.psel && !req.penable && !req.pwrite;
   assign mapped = (req.paddr == `LVM_CTRL_OFS) || (req.paddr == `LVM_STATUS_OFS) ||
                   (req.paddr == `LVM_EVENT_OFS) || (req.paddr == `LVM_MASK_OFS);

   // no wait state: ready and read data registered from the setup cycle
   always_ff @(posedge sys_clk) begin
      if (reset) begin
         pready  <= 1'b0;
         pslverr <= 1'b0;
         prdata  <= 32'h0000_0000;
      end else begin
         pready  <= req.psel && !req.penable;
         pslverr <= req.psel && !req.penable && !mapped;
         prdata  <= 32'h0000_0000;
         if (rd_en) begin
            case (req.paddr)
               `LVM_CTRL_OFS: begin
                  prdata[`LVM_CTRL_PWR_BIT]  <= cfg.monitor_power_enable;
                  prdata[`LVM_CTRL_RST_BIT]  <= cfg.low_voltage_reset_enable;
                  prdata[`LVM_CTRL_STOP_BIT] <= cfg.stop_mode_monitor_enable;
               end
               `LVM_STATUS_OFS: begin
                  prdata[`LVM_STAT_FLAG_BIT] <= low_voltage_flag;
               end
               `LVM_EVENT_OFS: begin
                  prdata[1:0] <= evt_status;
               end
               `LVM_MASK_OFS: begin
                  prdata[1:0] <= evt_mask;
               end
               default: begin
                  prdata <= 32'h0000_0000;
               end
            endcase
         end
      end
   end

   // configuration register
   always_ff @(posedge sys_clk) begin
      if (reset) begin
         cfg.monitor_power_enable     <= `LVM_CTRL_RESET;
         cfg.low_voltage_reset_enable <= `LVM_CTRL_RESET;
         cfg.stop_mode_monitor_enable <= `LVM_STOPEN_RESET;
      end else if (wr_en && req.paddr == `LVM_CTRL_OFS) begin
         cfg.monitor_power_enable     <= req.pwdata[`LVM_CTRL_PWR_BIT];
         cfg.low_voltage_reset_enable <= req.pwdata[`LVM_CTRL_RST_BIT];
         cfg.stop_mode_monitor_enable <= req.pwdata[`LVM_CTRL_STOP_BIT];
      end
   end

   // ----------------------------------------------------------------
   // system event flags and their masked event_irq interrupt request
   // ----------------------------------------------------------------
   assign evt_set[`LVM_EVT_RESET_BIT] = trip && (state == MON_RUN);
   assign evt_set[`LVM_EVT_FLAG_BIT]  = next_flag && !low_voltage_flag;

   // set wins over a simultaneous write-one clear
   always_ff @(posedge sys_clk) begin
      if (reset) begin
         evt_status <= `LVM_EVT_RESET;
      end else if (wr_en && req.paddr == `LVM_EVENT_OFS) begin
         evt_status <= (evt_status & ~req.pwdata[1:0]) | evt_set;
      end else begin
         evt_status <= evt_status | evt_set;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (reset) begin
         evt_mask <= `LVM_MASK_RESET;
      end else if (wr_en && req.paddr == `LVM_MASK_OFS) begin
         evt_mask <= req.pwdata[1:0];
      end
   end

   // masked off after reset so nothing is requested by default
   always_ff @(posedge sys_clk) begin
      if (reset) begin
         event_irq <= 1'b0;
      end else begin
         event_irq <= |(evt_status & evt_mask);
      end
   end

   // ----------------------------------------------------------------
   // assertions
   // ----------------------------------------------------------------
   localparam int CPU_A = CPU_FILTER;
   localparam int FLG_A = FLAG_SET;

   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (reset);

   power_off_quiet_a: assert property (
      !cfg.monitor_power_enable |=> ##1 !low_voltage_reset && $stable(low_voltage_flag))
      else $error("monitor acted with power bit clear");

   reset_needs_both_a: assert property (
      $rose(low_voltage_reset) |-> $past(cfg.monitor_power_enable, 2) &&
                                   $past(cfg.low_voltage_reset_enable, 2))
      else $error("reset produced without both enables");

   polled_no_reset_a: assert property (
      !cfg.low_voltage_reset_enable [*2] |=> !low_voltage_reset)
      else $error("reset produced in polled operation");

   filter_nine_a: assert property (
      $rose(low_voltage_reset) && !$past(bypass, 2) |-> $past(cpu_cnt, 2) == CPU_A)
      else $error("reset before filter count reached");

   release_one_a: assert property (
      state == MON_RESET && above && cpu_cycle_en |=> ##1 !low_voltage_reset)
      else $error("reset not released after cycle above rising level");

   pin_follows_a: assert property (
      reset_pin_oe == low_voltage_reset && !reset_pin_out)
      else $error("reset pin does not track low-voltage reset");

   flag_clear_a: assert property (
      active && above |=> !low_voltage_flag)
      else $error("flag not clear above rising level");

   flag_hold_a: assert property (
      !above && !below |=> $stable(low_voltage_flag))
      else $error("flag changed between trip levels");

   flag_timer_a: assert property (
      $rose(low_voltage_flag) |-> $past(xtal_cnt) == FLG_A)
      else $error("flag set at wrong crystal count");

   stop_bypass_a: assert property (
      bypass && below && cfg.monitor_power_enable && cfg.low_voltage_reset_enable
      && state == MON_RUN |-> ##2 low_voltage_reset)
      else $error("stop mode trip did not bypass filter");

   stop_inactive_a: assert property (
      stop_mode && !cfg.stop_mode_monitor_enable && state == MON_RUN
      |=> $stable(low_voltage_flag) && state == MON_RUN)
      else $error("monitor active in stop mode");

   filter_restart_a: assert property (
      !below |=> cpu_cnt == 4'h0)
      else $error("filter not restarted on good supply");

   event_irq_a: assert property (
      event_irq == $past(|(evt_status & evt_mask)))
      else $error("interrupt does not follow masked events");

   wait_filter_a: assert property (
      wait_mode && !stop_mode && cfg.monitor_power_enable && below && cpu_cycle_en &&
      cpu_cnt != CPU_MAX |=> cpu_cnt == $past(cpu_cnt) + 4'h1)
      else $error("filter stalled in wait mode");

   wait_trip_a: assert property (
      wait_mode && trip && state == MON_RUN |-> ##2 low_voltage_reset)
      else $error("wait mode trip did not reset");

   irq_masked_a: assert property (
      evt_mask == 2'h0 |=> !event_irq)
      else $error("event line raised while masked");

endmodule

// >>> low_voltage_reset_monitor_tb.sv
// self-checking testbench for the low-voltage reset monitor
`timescale 1ns/1ps

module low_voltage_reset_monitor_tb;
   logic        sys_clk;
   logic        reset;
   logic        psel;
   logic        penable;
   logic        pwrite;
   logic [7:0]  paddr;
   logic [31:0] pwdata;
   logic        pready;
   logic [31:0] prdata;
   logic        pslverr;
   logic        below_falling_raw;
   logic        above_rising_raw;
   logic        cpu_cycle_en;
   logic        crystal_clock_en;
   logic        wait_mode;
   logic        stop_mode;
   logic        low_voltage_reset;
   logic        reset_pin_out;
   logic        reset_pin_oe;
   logic        event_irq;
   logic [1:0]  supply_level;
   logic [31:0] rd;
   logic        err;
   int          miscompares;
   int          samples_checked;
   int          cycles;
   // open-drain pin with external pull-up
   wire         reset_pin_level = reset_pin_oe ? reset_pin_out : 1'b1;

   low_voltage_reset_monitor DUT (
      .sys_clk(sys_clk), .reset(reset), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
      .below_falling_raw(below_falling_raw), .above_rising_raw(above_rising_raw),
      .cpu_cycle_en(cpu_cycle_en), .crystal_clock_en(crystal_clock_en),
      .wait_mode(wait_mode), .stop_mode(stop_mode), .low_voltage_reset(low_voltage_reset),
      .reset_pin_out(reset_pin_out), .reset_pin_oe(reset_pin_oe), .event_irq(event_irq)
   );

   supply_comparator_model comparator (
      .supply_level(supply_level),
      .below_falling_raw(below_falling_raw),
      .above_rising_raw(above_rising_raw)
   );

   always #2.5 sys_clk = ~sys_clk;

   // ----------------------------------------------------------------
   // hang guard
   // ----------------------------------------------------------------
   always @(posedge sys_clk) begin
      cycles <= cycles + 1;
      if (cycles == 20000) begin
         miscompares++;
         end_sim();
      end
   end

   // ----------------------------------------------------------------
   // shared tasks
   // ----------------------------------------------------------------
   task automatic end_sim();
      $display("comparisons %0d mismatches %0d", samples_checked, miscompares);
      if (miscompares == 0 && samples_checked > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         miscompares++;
         $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic apb(input logic wr, input logic [7:0] addr, input logic [31:0] wd);
      @(posedge sys_clk);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= wr;
      paddr   <= addr;
      pwdata  <= wd;
      @(posedge sys_clk);
      penable <= 1'b1;
      // look at settled ready mid-cycle; the next rising edge completes
      @(negedge sys_clk);
      while (pready !== 1'b1) begin
         @(negedge sys_clk);
      end
      rd  = prdata;
      err = pslverr;
      @(posedge sys_clk);
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic idle(input int n);
      repeat (n) @(posedge sys_clk);
   endtask

   // supply change, then time for the input synchronisers to settle
   task automatic level(input logic [1:0] l);
      @(posedge sys_clk);
      supply_level <= l;
      idle(6);
   endtask

   task automatic pulses(input int n, input logic cpu, input logic xtal);
      repeat (n) begin
         @(posedge sys_clk);
         cpu_cycle_en     <= cpu;
         crystal_clock_en <= xtal;
         @(posedge sys_clk);
         cpu_cycle_en     <= 1'b0;
         crystal_clock_en <= 1'b0;
      end
   endtask

   // ----------------------------------------------------------------
   // scenarios
   // ----------------------------------------------------------------
   task automatic t_reset_values();
      apb(1'b0, 8'h00, 32'h0000_0000);
      check(rd, 32'h0000_0003);
      apb(1'b0, 8'h04, 32'h0000_0000);
      check(rd, 32'h0000_0000);
      apb(1'b0, 8'h08, 32'h0000_0000);
      check(rd, 32'h0000_0000);
      apb(1'b0, 8'h10, 32'h0000_0000);
      check(err, 1'b1);
   endtask

   task automatic t_polled();
      apb(1'b1, 8'h00, 32'h0000_0001);
      level(2'h2);
      pulses(20, 1'b1, 1'b0);
      pulses(31, 1'b0, 1'b1);
      apb(1'b0, 8'h04, 32'h0000_0000);
      check(rd, 32'h0000_0000);
      check(low_voltage_reset, 1'b0);
      pulses(10, 1'b0, 1'b1);
      apb(1'b0, 8'h04, 32'h0000_0000);
      check(rd, 32'h0000_0080);
      apb(1'b0, 8'h04, 32'h0000_0000);
      check(rd, 32'h0000_0080);
      level(2'h1);
      pulses(5, 1'b1, 1'b1);
      apb(1'b0, 8'h04, 32'h0000_0000);
      check(rd, 32'h0000_0080);
      level(2'h0);
      apb(1'b0, 8'h04, 32'h0000_0000);
      check(rd, 32'h0000_0000);
   endtask

   task automatic t_forced();
      apb(1'b1, 8'h00, 32'h0000_0003);
      level(2'h2);
      pulses(8, 1'b1, 1'b0);
      idle(4);
      check(low_voltage_reset, 1'b0);
      level(2'h1);
      level(2'h2);
      pulses(8, 1'b1, 1'b0);
      idle(4);
      check(low_voltage_reset, 1'b0);
      pulses(1, 1'b1, 1'b0);
      idle(4);
      check(low_voltage_reset, 1'b1);
      check(reset_pin_level, 1'b0);
      check(event_irq, 1'b0);
      level(2'h0);
      check(low_voltage_reset, 1'b1);
      pulses(1, 1'b1, 1'b0);
      idle(4);
      check(low_voltage_reset, 1'b0);
      check(reset_pin_level, 1'b1);
   endtask

   task automatic t_events();
      apb(1'b0, 8'h08, 32'h0000_0000);
      check(rd, 32'h0000_0003);
      apb(1'b1, 8'h0C, 32'h0000_0001);
      idle(2);
      check(event_irq, 1'b1);
      apb(1'b1, 8'h08, 32'h0000_0001);
      idle(2);
      check(event_irq, 1'b0);
      apb(1'b1, 8'h0C, 32'h0000_0000);
      apb(1'b1, 8'h08, 32'h0000_0002);
   endtask

   task automatic t_power_off();
      apb(1'b1, 8'h00, 32'h0000_0002);
      level(2'h2);
      pulses(12, 1'b1, 1'b1);
      pulses(45, 1'b0, 1'b1);
      check(low_voltage_reset, 1'b0);
      apb(1'b0, 8'h04, 32'h0000_0000);
      check(rd, 32'h0000_0000);
      level(2'h0);
   endtask

   task automatic t_wait();
      wait_mode <= 1'b1;
      apb(1'b1, 8'h00, 32'h0000_0003);
      level(2'h2);
      pulses(40, 1'b1, 1'b1);
      apb(1'b0, 8'h04, 32'h0000_0000);
      check(rd, 32'h0000_0080);
      check(low_voltage_reset, 1'b1);
      level(2'h0);
      pulses(1, 1'b1, 1'b0);
      idle(4);
      wait_mode <= 1'b0;
      check(low_voltage_reset, 1'b0);
   endtask

   task automatic t_stop();
      stop_mode <= 1'b1;
      apb(1'b1, 8'h00, 32'h0000_0007);
      level(2'h2);
      idle(4);
      check(low_voltage_reset, 1'b1);
      level(2'h0);
      idle(4);
      check(low_voltage_reset, 1'b0);
      apb(1'b1, 8'h00, 32'h0000_0003);
      level(2'h2);
      pulses(12, 1'b1, 1'b1);
      pulses(45, 1'b0, 1'b1);
      check(low_voltage_reset, 1'b0);
      apb(1'b0, 8'h04, 32'h0000_0000);
      check(rd, 32'h0000_0000);
      level(2'h0);
      stop_mode <= 1'b0;
   endtask

   task automatic t_sys_reset();
      apb(1'b1, 8'h00, 32'h0000_0001);
      level(2'h2);
      pulses(41, 1'b0, 1'b1);
      apb(1'b0, 8'h04, 32'h0000_0000);
      check(rd, 32'h0000_0080);
      @(posedge sys_clk);
      reset <= 1'b1;
      idle(2);
      reset <= 1'b0;
      apb(1'b0, 8'h04, 32'h0000_0000);
      check(rd, 32'h0000_0000);
      level(2'h0);
   endtask

   // ----------------------------------------------------------------
   // main sequence
   // ----------------------------------------------------------------
   initial begin
      sys_clk = 1'b0;
      reset = 1'b1;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h0000_0000;
      cpu_cycle_en = 1'b0;
      crystal_clock_en = 1'b0;
      wait_mode = 1'b0;
      stop_mode = 1'b0;
      supply_level = 2'h0;
      miscompares = 0;
      samples_checked = 0;
      cycles = 0;
      idle(8);
      reset <= 1'b0;
      t_reset_values();
      t_polled();
      t_forced();
      t_events();
      t_power_off();
      t_wait();
      t_stop();
      t_sys_reset();
      end_sim();
   end
endmodule

// >>> lvm_consts.svh
// constant definitions for the low-voltage reset monitor
`ifndef LVM_CONSTS_SVH
`define LVM_CONSTS_SVH

// ----------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------
`define LVM_CTRL_OFS       8'h00
`define LVM_STATUS_OFS     8'h04
`define LVM_EVENT_OFS      8'h08
`define LVM_MASK_OFS       8'h0C

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define LVM_CTRL_PWR_BIT   0
`define LVM_CTRL_RST_BIT   1
`define LVM_CTRL_STOP_BIT  2
`define LVM_STAT_FLAG_BIT  7
`define LVM_EVT_RESET_BIT  0
`define LVM_EVT_FLAG_BIT   1

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define LVM_CTRL_RESET     1'b1
`define LVM_STOPEN_RESET   1'b0
`define LVM_EVT_RESET      2'h0
`define LVM_MASK_RESET     2'h0

// ----------------------------------------------------------------
// filter counts
// ----------------------------------------------------------------
`define LVM_CPU_FILTER     9
`define LVM_FLAG_MIN       32
`define LVM_FLAG_MAX       40
`define LVM_FLAG_SET       36

`endif

// >>> lvm_pkg.sv
// types shared by the low-voltage reset monitor
package lvm_pkg;

   // ----------------------------------------------------------------
   // configuration bits
   // ----------------------------------------------------------------
   typedef struct packed {
      logic stop_mode_monitor_enable;
      logic low_voltage_reset_enable;
      logic monitor_power_enable;
   } cfg_s;

   // ----------------------------------------------------------------
   // apb request group
   // ----------------------------------------------------------------
   typedef struct packed {
      logic        psel;
      logic        penable;
      logic        pwrite;
      logic [7:0]  paddr;
      logic [31:0] pwdata;
   } apb_req_s;

   // ----------------------------------------------------------------
   // reset generator state
   // ----------------------------------------------------------------
   typedef enum logic [0:0] {
      MON_RUN,
      MON_RESET
   } mon_state_e;

endpackage

// >>> supply_comparator_model.sv
// analog supply comparator model with fixed trip levels
`timescale 1ns/1ps

module supply_comparator_model (
   input  wire logic [1:0] supply_level,
   output logic            below_falling_raw,
   output logic            above_rising_raw
);
   // ----------------------------------------------------------------
   // level 0 above rising trip, 1 in hysteresis band, 2 at or below falling trip
   // ----------------------------------------------------------------
   assign below_falling_raw = (supply_level == 2'h2);
   assign above_rising_raw  = (supply_level == 2'h0);
endmodule
